// File: rtl/sfc_pkg.sv
// package: register map, field layout, reset values and states of the serial port configuration block
package sfc_pkg;
  // ---------------------------------------------------------------
  // register addresses (special-function-register space)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'hF8;
  localparam logic [7:0] DATA_ADDR   = 8'h9B;
  localparam logic [7:0] CFG_ADDR    = 8'h9A;
  localparam logic [7:0] CKDIV_ADDR  = 8'h9D;
  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  localparam int         CFG_PHA_BIT = 7;
  localparam int         CFG_POL_BIT = 6;
  localparam int         CFG_BC_LSB  = 3;
  localparam int         CFG_FL_LSB  = 0;
  localparam logic [7:0] CFG_RESET   = 8'h07;
  localparam logic [7:0] CFG_WMASK   = 8'hC7;
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int         CTL_DONE_BIT = 7;
  localparam int         CTL_WCOL_BIT = 6;
  localparam int         CTL_BUSY_BIT = 3;
  localparam int         CTL_MST_BIT  = 1;
  localparam int         CTL_EN_BIT   = 0;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [7:0] CKDIV_RESET  = 8'h00;

  typedef struct packed {
    logic       clock_phase_sel;
    logic       clock_polarity_sel;
    logic [2:0] frame_length_sel;
  } sfc_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LEAD  = 3'b010,
    ST_TRAIL = 3'b100
  } sfc_state_t;
endpackage : sfc_pkg

// File: rtl/sfc_half_period.sv
// module: serial clock half-period enable generator
`timescale 1ns/100ps
module sfc_half_period #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] divider,
  // enable out
  output logic              tick
);
  logic [W:0] cnt_r;
  logic [W:0] cnt_nxt;
  logic [W:0] limit;

  // half period is divider+1 system clocks, so scl = mclk/(2*(div+1))
  assign limit = {1'b0, divider};
  assign tick  = run && (cnt_r == limit);

  always_comb begin
    cnt_nxt = cnt_r;
    if (!run || tick) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : sfc_half_period

// File: rtl/sfc_port.sv
// module: serial port with configuration register, bit progress count and master shifter
//
// Function
// - phase bit 0 samples on first clock edge, 1 on second edge.
// - polarity bit sets serial clock idle level, 0 low, 1 high.
// - read-only three-bit count shows which bit of word was sent.
// - frame length code n shifts n+1 bits in master mode only.
// - configuration register resets to 00000111.
// - port controlled by control, data, configuration and divider registers.
// - serial data shifted most significant bit first both directions.
// - data write when enabled in master mode and idle starts transfer; done flag set at end.
`timescale 1ns/100ps
module sfc_port #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // special-function-register access
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // serial pins
  output logic            sck_o,
  output logic            sck_oe,
  output logic            mosi_o,
  output logic            mosi_oe,
  input  wire logic       miso_i
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  sfc_pkg::sfc_cfg_t  cfg_r, cfg_nxt;
  logic [2:0]         bit_progress_count_r, bit_progress_count_nxt;
  logic [7:0]         ctrl_r, ctrl_nxt;
  logic [7:0]         serial_clock_divider_r, serial_clock_divider_nxt;
  logic [7:0]         shift_r, shift_nxt;
  logic [7:0]         rx_buf_r, rx_buf_nxt;
  logic [2:0]         bits_left_r, bits_left_nxt;
  logic               sck_r, sck_nxt;
  logic               sample_r, sample_nxt;
  logic               miso_s1_r, miso_s2_r;
  sfc_pkg::sfc_state_t state_r, state_nxt;
  logic               tick;
  logic               port_enable, master_enable, busy;
  logic               wr_cfg, wr_ctl, wr_dat, wr_div;

  assign port_enable   = ctrl_r[sfc_pkg::CTL_EN_BIT];
  assign master_enable = ctrl_r[sfc_pkg::CTL_MST_BIT];
  assign busy          = (state_r != sfc_pkg::ST_IDLE);
  assign wr_cfg = sfr_wr && (sfr_addr == sfc_pkg::CFG_ADDR);
  assign wr_ctl = sfr_wr && (sfr_addr == sfc_pkg::CTRL_ADDR);
  assign wr_dat = sfr_wr && (sfr_addr == sfc_pkg::DATA_ADDR);
  assign wr_div = sfr_wr && (sfr_addr == sfc_pkg::CKDIV_ADDR);

  // ---------------------------------------------------------------
  // serial clock half-period enable
  // ---------------------------------------------------------------
  // runs only while busy so every frame opens with a full half period
  sfc_half_period #(
    .W       (DIV_W)
  ) u_half (
    .mclk    (mclk),
    .reset_n (reset_n),
    .run     (busy),
    .divider (serial_clock_divider_r[DIV_W-1:0]),
    .tick    (tick)
  );

  // ---------------------------------------------------------------
  // miso synchroniser
  // ---------------------------------------------------------------
  // two clocks of latency; a divider below 2 would sample stale data
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      miso_s1_r <= miso_i;
      miso_s2_r <= miso_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // register writes and transfer engine
  // ---------------------------------------------------------------
  always_comb begin
    cfg_nxt                  = cfg_r;
    ctrl_nxt                 = ctrl_r;
    serial_clock_divider_nxt = serial_clock_divider_r;
    shift_nxt                = shift_r;
    rx_buf_nxt               = rx_buf_r;
    bits_left_nxt            = bits_left_r;
    bit_progress_count_nxt   = bit_progress_count_r;
    sck_nxt                  = sck_r;
    sample_nxt               = sample_r;
    state_nxt                = state_r;
    // counter bits are never written; only phase, polarity, length
    if (wr_cfg) begin
      cfg_nxt.clock_phase_sel    = sfr_wdata[sfc_pkg::CFG_PHA_BIT];
      cfg_nxt.clock_polarity_sel = sfr_wdata[sfc_pkg::CFG_POL_BIT];
      cfg_nxt.frame_length_sel   = sfr_wdata[sfc_pkg::CFG_FL_LSB +: 3];
    end
    if (wr_div) begin
      serial_clock_divider_nxt = sfr_wdata;
    end
    if (wr_ctl) begin
      // busy is read only; done and collision writable so software can clear
      ctrl_nxt = {sfr_wdata[7:4], ctrl_r[sfc_pkg::CTL_BUSY_BIT], sfr_wdata[2:0]};
    end
    if (!busy) begin
      sck_nxt = cfg_r.clock_polarity_sel;
    end
    case (state_r)
      sfc_pkg::ST_IDLE: begin
        if (wr_dat && port_enable && master_enable) begin
          shift_nxt              = sfr_wdata;
          bits_left_nxt          = cfg_r.frame_length_sel;
          bit_progress_count_nxt = 3'h0;
          state_nxt              = sfc_pkg::ST_LEAD;
        end
      end
      sfc_pkg::ST_LEAD: begin
        if (tick) begin
          sck_nxt   = ~sck_r;
          state_nxt = sfc_pkg::ST_TRAIL;
          // phase 0 samples on leading edge
          if (!cfg_r.clock_phase_sel) begin
            sample_nxt = miso_s2_r;
          end
        end
      end
      sfc_pkg::ST_TRAIL: begin
        if (tick) begin
          sck_nxt     = ~sck_r;
          if (cfg_r.clock_phase_sel) begin
            sample_nxt = miso_s2_r;
          end
          shift_nxt = {shift_r[6:0], cfg_r.clock_phase_sel ? miso_s2_r : sample_r};
          // last bit: count holds its index until the next transfer
          // received word goes to a separate copy so reads see a whole word
          if (bits_left_r == 3'h0) begin
            state_nxt                        = sfc_pkg::ST_IDLE;
            rx_buf_nxt                       = {shift_r[6:0], cfg_r.clock_phase_sel ? miso_s2_r : sample_r};
            ctrl_nxt[sfc_pkg::CTL_DONE_BIT]  = 1'b1;
          end else begin
            bits_left_nxt          = bits_left_r - 3'h1;
            bit_progress_count_nxt = bit_progress_count_r + 3'h1;
            state_nxt              = sfc_pkg::ST_LEAD;
          end
        end
      end
      default: begin
        state_nxt = sfc_pkg::ST_IDLE;
      end
    endcase
    // write during transfer is dropped and flagged; set wins over clear
    if (wr_dat && busy) begin
      ctrl_nxt[sfc_pkg::CTL_WCOL_BIT] = 1'b1;
    end
    if (!port_enable && !(wr_ctl && sfr_wdata[sfc_pkg::CTL_EN_BIT])) begin
      state_nxt = sfc_pkg::ST_IDLE;
    end
    ctrl_nxt[sfc_pkg::CTL_BUSY_BIT] = (state_nxt != sfc_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r                  <= sfc_pkg::sfc_cfg_t'({sfc_pkg::CFG_RESET[7:6], sfc_pkg::CFG_RESET[2:0]});
      bit_progress_count_r   <= sfc_pkg::CFG_RESET[5:3];
      ctrl_r                 <= sfc_pkg::CTL_RESET;
      serial_clock_divider_r <= sfc_pkg::CKDIV_RESET;
      shift_r                <= 8'h00;
      rx_buf_r               <= 8'h00;
      bits_left_r            <= 3'h0;
      sck_r                  <= 1'b0;
      sample_r               <= 1'b0;
      state_r                <= sfc_pkg::ST_IDLE;
    end else begin
      cfg_r                  <= cfg_nxt;
      bit_progress_count_r   <= bit_progress_count_nxt;
      ctrl_r                 <= ctrl_nxt;
      serial_clock_divider_r <= serial_clock_divider_nxt;
      shift_r                <= shift_nxt;
      rx_buf_r               <= rx_buf_nxt;
      bits_left_r            <= bits_left_nxt;
      sck_r                  <= sck_nxt;
      sample_r               <= sample_nxt;
      state_r                <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // no slave mode: pins are released unless enabled as master
  assign sck_o   = sck_r;
  assign sck_oe  = port_enable && master_enable;
  assign mosi_o  = shift_r[7];
  assign mosi_oe = port_enable && master_enable;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        sfc_pkg::CFG_ADDR:   sfr_rdata = {cfg_r.clock_phase_sel, cfg_r.clock_polarity_sel,
                                          bit_progress_count_r, cfg_r.frame_length_sel};
        sfc_pkg::CTRL_ADDR:  sfr_rdata = ctrl_r;
        sfc_pkg::DATA_ADDR:  sfr_rdata = rx_buf_r;
        sfc_pkg::CKDIV_ADDR: sfr_rdata = serial_clock_divider_r;
        default:             sfr_rdata = 8'h00;
      endcase
    end
  end
endmodule : sfc_port

// File: test/sfc_port_props.sv
// checker: port-level properties of the serial port
`timescale 1ns/100ps
module sfc_port_props (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // register access
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // serial pins
  input wire logic       sck_o,
  input wire logic       sck_oe,
  input wire logic       mosi_o,
  input wire logic       mosi_oe,
  input wire logic       miso_i
);
  logic [7:0] cfg_r, ctl_r;
  logic [4:0] edg_r;
  logic       busy_r, seen_r, sck_r;
  wire        pol = cfg_r[6];
  wire        wd7 = sfr_wdata[7];
  wire  [4:0] tgt = {1'b0, cfg_r[2:0], 1'b0} + 5'h02;
  wire        tog = busy_r && sck_o != sck_r;
  wire        cw  = sfr_wr && sfr_addr == sfc_pkg::CFG_ADDR;
  wire        rc  = sfr_rd && sfr_addr == sfc_pkg::CFG_ADDR;
  // a refused write while busy must not restart the edge count
  wire        dw  = sfr_wr && sfr_addr == sfc_pkg::DATA_ADDR && sck_oe && !busy_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= sfc_pkg::CFG_RESET;
      ctl_r <= 8'h00;
      edg_r <= 5'h00;
      busy_r <= 1'b0;
      seen_r <= 1'b0;
      sck_r <= 1'b0;
    end else begin
      if (cw) cfg_r <= sfr_wdata;
      if (cw) seen_r <= 1'b1;
      if (sfr_wr && sfr_addr == sfc_pkg::CTRL_ADDR) ctl_r <= sfr_wdata;
      sck_r <= sck_o;
      if (dw) edg_r <= 5'h00;
      else if (tog) edg_r <= edg_r + 5'h01;
      if (dw) busy_r <= 1'b1;
      else if (tog && edg_r + 5'h01 == tgt) busy_r <= 1'b0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence data_start; dw; endsequence
  sequence frame_end; sfr_rd && sfr_addr == sfc_pkg::CTRL_ADDR && sfr_rdata[7] && !sfr_rdata[3]; endsequence
  reset_value_a: assert property (rc && !seen_r |-> sfr_rdata == sfc_pkg::CFG_RESET)
    else $error("config read differs from reset value");
  cfg_write_a: assert property (cw ##2 rc |-> (sfr_rdata & 8'hC7) == ($past(sfr_wdata, 2) & 8'hC7))
    else $error("config fields not stored");
  unmapped_read_a: assert property (sfr_rd && !(sfr_addr inside {8'hF8, 8'h9B, 8'h9A, 8'h9D}) |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  oe_enable_a: assert property (sck_oe == (ctl_r[0] && ctl_r[1]) && mosi_oe == sck_oe)
    else $error("pin enables disagree with control");
  msb_first_a: assert property (data_start |=> mosi_o == $past(wd7))
    else $error("first bit out is not the top bit");
  count_restart_a: assert property (data_start ##2 rc |-> sfr_rdata[5:3] == 3'h0)
    else $error("bit count not restarted");
  frame_len_a: assert property (frame_end |-> ##1 edg_r == tgt)
    else $error("serial clock edge count wrong");
  bit_count_a: assert property (rc && seen_r && !busy_r && edg_r == tgt |-> sfr_rdata[5:3] == cfg_r[2:0])
    else $error("bit count wrong after frame");
  idle_level_a: assert property (sfr_rd && sfr_addr == 8'hF8 && !sfr_rdata[3] && pol == $past(pol) |-> sck_o == pol)
    else $error("serial clock idle level wrong");
endmodule : sfc_port_props

// File: test/sfc_slave_model.sv
// model: external serial slave on the far side of the port
`timescale 1ns/100ps
module sfc_slave_model (
  // serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // bench side
  input  wire logic       sel,
  input  wire logic       cpha,
  input  wire logic       cpol,
  input  wire logic [7:0] tx,
  output logic      [7:0] rx
);
  logic [7:0] sh;
  logic       mosi_q;
  // hold time: sample what stood just before the edge
  assign #5 mosi_q = mosi;
  initial miso = 1'b1;
  always @(posedge sel) begin
    sh = tx;
    rx = 8'h00;
    if (!cpha) miso = tx[7];
  end
  // no pull on the line: released level is unreliable
  always @(negedge sel) miso = ~miso;
  always @(sck) if (sel) begin
    if ((sck != cpol) != cpha) rx = {rx[6:0], mosi_q};
    else begin
      if (cpha) miso = sh[7];
      sh = sh << 1;
      if (!cpha) miso = sh[7];
    end
  end
endmodule : sfc_slave_model

// File: test/sfc_port_tb.sv
// bench: corner and random frames through the serial port against a slave model
`timescale 1ns/100ps
module sfc_port_tb;
  logic        mclk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, sel = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, cfg = 8'h00, stx = 8'h00, sfr_rdata, srx;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso;
  logic [31:0] lfsr = 32'hAB66;
  int          miscompares = 0, samples_checked = 0;
  always #20 mclk = ~mclk;
  sfc_port uut (.mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso));
  sfc_slave_model slave (.sck(sck_o), .mosi(mosi_o), .miso(miso), .sel(sel), .cpha(cfg[7]),
    .cpol(cfg[6]), .tx(stx), .rx(srx));
  function automatic logic [7:0] mrx(input logic [7:0] m, s, input int n);
    return (m << n) | (s >> (8 - n));
  endfunction : mrx
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    d = sfr_rdata;
    sfr_rd <= 1'b0;
  endtask : rdr
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // far above the thousand or so cycles the frames need
  initial begin
    #2000000;
    miscompares++;
    finish_test;
  end
  initial begin
    logic [7:0] d, m;
    int n;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rdr(sfc_pkg::CFG_ADDR, d);
    chk(d, 8'h07);
    rdr(sfc_pkg::CTRL_ADDR, d);
    chk(d, 8'h00);
    rdr(8'h55, d);
    chk(d, 8'h00);
    wr(sfc_pkg::DATA_ADDR, 8'hA5);
    rdr(sfc_pkg::CTRL_ADDR, d);
    chk(d, 8'h00);
    wr(sfc_pkg::CFG_ADDR, 8'hFF);
    rdr(sfc_pkg::CFG_ADDR, d);
    chk(d, 8'hC7);
    $display("register test done");
    for (int k = 0; k < 16; k++) begin
      lfsr = lfsr_step(lfsr);
      cfg = (k < 4) ? {k[1:0], 3'h0, k[0] ? 3'h7 : 3'h0} : (lfsr[7:0] & 8'hC7);
      m = lfsr[15:8];
      stx = lfsr[23:16];
      n = cfg[2:0] + 1;
      wr(sfc_pkg::CTRL_ADDR, 8'h00);
      wr(sfc_pkg::CKDIV_ADDR, {7'h01, lfsr[24]});
      wr(sfc_pkg::CFG_ADDR, cfg);
      wr(sfc_pkg::CTRL_ADDR, 8'h03);
      sel <= 1'b1;
      wr(sfc_pkg::DATA_ADDR, m);
      rdr(sfc_pkg::CFG_ADDR, d);
      chk({5'h00, d[5:3]}, 8'h00);
      if (k == 1) wr(sfc_pkg::DATA_ADDR, ~m);
      d = 8'h08;
      for (int t = 0; t < 200 && d[3]; t++) rdr(sfc_pkg::CTRL_ADDR, d);
      chk(d, (k == 1) ? 8'hC3 : 8'h83);
      sel <= 1'b0;
      chk({7'h00, sck_o}, {7'h00, cfg[6]});
      rdr(sfc_pkg::DATA_ADDR, d);
      chk(d, mrx(m, stx, n));
      rdr(sfc_pkg::CFG_ADDR, d);
      chk(d, {cfg[7:6], cfg[2:0], cfg[2:0]});
      chk(srx & (8'hFF >> (8 - n)), m >> (8 - n));
      $display("frame %0d done", k);
    end
    finish_test;
  end
endmodule : sfc_port_tb
bind sfc_port sfc_port_props chk_i (.mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sck_o(sck_o), .sck_oe(sck_oe),
  .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i));
